// ===== ast_pkg.sv
package ast_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] AST_OFF_INTCTL = 8'h00;
    localparam logic [7:0] AST_OFF_FLAGS  = 8'h04;
    localparam logic [7:0] AST_OFF_ENAB   = 8'h08;
    localparam logic [7:0] AST_OFF_PRIO   = 8'h0C;
    localparam logic [7:0] AST_OFF_RCSC   = 8'h10;
    localparam logic [7:0] AST_OFF_TXBUF  = 8'h14;
    localparam logic [7:0] AST_OFF_TXSC   = 8'h18;
    localparam logic [7:0] AST_OFF_BAUD   = 8'h1C;
    localparam logic [7:0] AST_OFF_RXBUF  = 8'h20;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int AST_B_GIE   = 7; // interrupt_control
    localparam int AST_B_RECEIVE_COMPLETE_FLAG  = 5; // flags / enables / priority
    localparam int AST_B_TX_BUFFER_EMPTY_FLAG  = 4;
    localparam int AST_B_PORT_ENABLE  = 7; // receive_status_control
    localparam int AST_B_RX9   = 6;
    localparam int AST_B_CONTINUOUS_RECEIVE_ENABLE  = 4;
    localparam int AST_B_ADDRESS_DETECT_ENABLE = 3;
    localparam int AST_B_FRAMING_ERROR_FLAG  = 2;
    localparam int AST_B_OVERRUN_ERROR_FLAG  = 1;
    localparam int AST_B_RECEIVED_NINTH_BIT  = 0;
    localparam int AST_B_TX9   = 6; // transmit_status_control
    localparam int AST_B_TRANSMIT_ENABLE  = 5;
    localparam int AST_B_SYNC  = 4;
    localparam int AST_B_RSV   = 3;
    localparam int AST_B_HIGH_SPEED_BAUD  = 2;
    localparam int AST_B_SHIFTER_EMPTY_STATUS  = 1;
    localparam int AST_B_TRANSMIT_NINTH_BIT  = 0;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] AST_RST_INTCTL = 8'h00;
    localparam logic [7:0] AST_RST_ENAB   = 8'h00;
    localparam logic [7:0] AST_RST_PRIO   = 8'hFF;
    localparam logic [7:0] AST_RST_RCSC   = 8'h00;
    localparam logic [7:0] AST_RST_TXSC   = 8'h02;
    localparam logic [7:0] AST_RST_BAUD   = 8'h00;
    // ----------------------------------------
    // Timing ratios
    // ----------------------------------------
    localparam logic [3:0] AST_OS_LAST  = 4'hF; // 16 ticks per bit
    localparam logic [3:0] AST_OS_MID   = 4'h7; // start-bit centre
    localparam logic [1:0] AST_SLOW_LAST = 2'h3; // x64 = 4 * x16
    localparam logic [3:0] AST_TX_BITS8 = 4'hA; // start+8+stop
    localparam logic [3:0] AST_TX_BITS9 = 4'hB; // start+9+stop
    localparam logic [3:0] AST_RX_LAST8 = 4'h7;
    localparam logic [3:0] AST_RX_LAST9 = 4'h8;
    // Receiver states
    typedef enum logic [1:0] {
        AST_RX_IDLE, AST_RX_START, AST_RX_DATA, AST_RX_STOP
    } ast_rx_t;
endpackage

// ===== ast_uart.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Reload shifter only after previous stop bit
// - Load takes one cycle, then buffer empty
// - Empty flag set by hardware, cleared by write
// - Transmit request gated by its enable
// - Readable shifter-empty status, polled only
// - Transmit shifter has no register address
// - Transmit enable sets buffer-empty flag
// - Flag clears on second cycle after write
// - Baud from high-speed bit and divisor
// - Ninth transmit bit from its field
// - Buffer write starts transmission when enabled
// - Receiver oversamples sixteen times per bit
// - Reception only while continuous enable set
// - Complete word sets receive-complete flag
// - Nine-bit receive captures nine data bits
// - Ninth bit and errors in status register
// - Clearing continuous enable clears errors
// - Address detect filters, off passes all
// - Receive request needs both enables
// - Priority bit selects receive request level
// - Start, eight/nine LSB-first bits, stop
// - Generator runs x16 or x64 bit rate
// - Transmitter and receiver independent, shared settings
module ast_uart
    import ast_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_in,
    output logic             tx_out,
    output logic             tx_out_enable,
    output logic             tx_irq_request,
    output logic             rx_irq_request,
    output logic             rx_irq_high_priority
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]  intctl;   // Global enable lives here
        logic [7:0]  enab;     // Peripheral enables
        logic [7:0]  prio;     // Peripheral priorities
        logic [7:0]  rcsc;     // Receive control, 2:0 unused
        logic [7:0]  txsc;     // Transmit control, bit 1 unused
        logic [7:0]  baud;     // Baud divisor
        logic [7:0]  tx_data;  // Transmit buffer
        logic        buf_full; // Transmit buffer holds a word
        logic        tx_buffer_empty_flag;     // Buffer-empty flag
        logic        tx_busy;  // Shifter holds a frame
        logic [10:0] tx_sh;    // Hidden transmit shifter
        logic [3:0]  tx_bits;  // Bits left in frame
        logic [3:0]  tx_os;    // Ticks within bit
        logic [7:0]  brg_cnt;  // Baud down counter
        logic [1:0]  brg_q;    // Slow-mode divide by four
        ast_rx_t     rx_st;    // Receiver state
        logic [3:0]  rx_os;    // Ticks within bit
        logic [3:0]  rx_bits;  // Data bits taken
        logic [8:0]  rx_sh;    // Receive shifter
        logic [7:0]  rx_data;  // Receive buffer
        logic        received_ninth_bit;     // Received ninth bit
        logic        framing_error_flag;     // Framing error
        logic        overrun_error_flag;     // Overrun error
        logic        receive_complete_flag;     // Receive-complete flag
        logic [31:0] prdata;   // Read data, caught at setup
        logic        pslverr;  // Unmapped address seen
    } ast_state_t;

    ast_state_t s;      // Registered state
    ast_state_t next_s; // Next state

    // ----------------------------------------
    // Decoded controls
    // ----------------------------------------
    logic setup;    // APB setup phase
    logic acc;      // APB access phase, zero wait
    logic port_enable;     // Port enable
    logic async_on; // Port on and in async mode
    logic tx_on;    // Transmitter running
    logic rx_on;    // Receiver running
    logic brg_tick; // Baud generator output
    logic os_tick;  // x16 bit-rate enable
    logic tx_load;  // Buffer moves into shifter
    logic rd_rx;    // Receive buffer read
    logic rx_full;  // Receive buffer still unread
    logic ninth;    // Ninth bit of finished word
    logic [7:0] rx_word;

    assign setup    = psel & ~penable;
    assign acc      = psel & penable;
    assign port_enable     = s.rcsc[AST_B_PORT_ENABLE];
    // Sync select keeps this async-only logic parked
    assign async_on = port_enable & ~s.txsc[AST_B_SYNC];
    assign tx_on    = async_on & s.txsc[AST_B_TRANSMIT_ENABLE];
    assign rx_on    = async_on & s.rcsc[AST_B_CONTINUOUS_RECEIVE_ENABLE];
    // count divisor+1 cycles, slow mode adds /4
    assign brg_tick = async_on & (s.brg_cnt == 8'h00);
    assign os_tick  = brg_tick
        & (s.txsc[AST_B_HIGH_SPEED_BAUD] | (s.brg_q == AST_SLOW_LAST));
    assign tx_load  = tx_on & ~s.tx_busy & s.buf_full;
    assign rd_rx    = acc & ~pwrite & (paddr == AST_OFF_RXBUF);
    // A read in the same cycle frees the buffer first
    assign rx_full  = s.receive_complete_flag & ~rd_rx;
    assign ninth    = s.rx_sh[8];
    assign rx_word  = s.rcsc[AST_B_RX9] ? s.rx_sh[7:0]
                                        : s.rx_sh[8:1];

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        next_s = s;
        // Baud generator, shared by both directions
        if (!async_on) begin
            next_s.brg_cnt = s.baud;
            next_s.brg_q   = 2'h0;
        end else if (brg_tick) begin
            next_s.brg_cnt = s.baud;
            next_s.brg_q   = s.brg_q + 2'h1;
        end else begin
            next_s.brg_cnt = s.brg_cnt - 8'h01;
        end

        // Flag follows the buffer one cycle late, so a
        // write shows on the second cycle after it
        next_s.tx_buffer_empty_flag = tx_on & ~s.buf_full;

        // Transmitter
        if (!tx_on) begin
            // Disable drops the word and the frame
            next_s.buf_full = 1'b0;
            next_s.tx_busy  = 1'b0;
            next_s.tx_os    = 4'h0;
        end else if (tx_load) begin
            // One-cycle move, buffer empty afterwards
            next_s.buf_full = 1'b0;
            next_s.tx_busy  = 1'b1;
            next_s.tx_os    = 4'h0;
            // Stop bit on top; idle ones shift in behind it
            next_s.tx_sh    = {1'b1,
                s.txsc[AST_B_TX9] ? s.txsc[AST_B_TRANSMIT_NINTH_BIT] : 1'b1,
                s.tx_data, 1'b0};
            next_s.tx_bits  = s.txsc[AST_B_TX9] ? AST_TX_BITS9
                                                : AST_TX_BITS8;
        end else if (s.tx_busy && os_tick) begin
            next_s.tx_os = s.tx_os + 4'h1;
            if (s.tx_os == AST_OS_LAST) begin
                // LSB first, idle level fills from the top
                next_s.tx_sh   = {1'b1, s.tx_sh[10:1]};
                next_s.tx_bits = s.tx_bits - 4'h1;
                if (s.tx_bits == 4'h1) begin
                    next_s.tx_busy = 1'b0;
                end
            end
        end

        // Receiver, x16 oversampling
        if (!rx_on) begin
            next_s.rx_st = AST_RX_IDLE;
            next_s.rx_os = 4'h0;
        end else begin
            case (s.rx_st)
                AST_RX_IDLE: begin
                    // Overrun blocks until errors are cleared
                    if (!s.overrun_error_flag && !rx_in) begin
                        next_s.rx_st = AST_RX_START;
                        next_s.rx_os = 4'h0;
                    end
                end
                AST_RX_START: begin
                    if (os_tick) begin
                        next_s.rx_os = s.rx_os + 4'h1;
                        if (s.rx_os == AST_OS_MID) begin
                            // Glitch shorter than half a bit
                            next_s.rx_st = rx_in ? AST_RX_IDLE
                                                 : AST_RX_DATA;
                            next_s.rx_os   = 4'h0;
                            next_s.rx_bits = 4'h0;
                        end
                    end
                end
                AST_RX_DATA: begin
                    if (os_tick) begin
                        next_s.rx_os = s.rx_os + 4'h1;
                        if (s.rx_os == AST_OS_LAST) begin
                            next_s.rx_sh   = {rx_in, s.rx_sh[8:1]};
                            next_s.rx_bits = s.rx_bits + 4'h1;
                            if (s.rx_bits == (s.rcsc[AST_B_RX9]
                                ? AST_RX_LAST9 : AST_RX_LAST8)) begin
                                next_s.rx_st = AST_RX_STOP;
                            end
                        end
                    end
                end
                AST_RX_STOP: begin
                    if (os_tick) begin
                        next_s.rx_os = s.rx_os + 4'h1;
                        if (s.rx_os == AST_OS_LAST) begin
                            next_s.rx_st = AST_RX_IDLE;
                        end
                    end
                end
                default: next_s.rx_st = AST_RX_IDLE;
            endcase
        end

        // ----------------------------------------
        // APB setup: snapshot read data
        // ----------------------------------------
        if (setup) begin
            next_s.prdata  = 32'h0000_0000;
            next_s.pslverr = 1'b0;
            if (paddr == AST_OFF_INTCTL) begin
                next_s.prdata[7:0] = s.intctl;
            end else if (paddr == AST_OFF_FLAGS) begin
                next_s.prdata[AST_B_RECEIVE_COMPLETE_FLAG] = s.receive_complete_flag;
                next_s.prdata[AST_B_TX_BUFFER_EMPTY_FLAG] = s.tx_buffer_empty_flag;
            end else if (paddr == AST_OFF_ENAB) begin
                next_s.prdata[7:0] = s.enab;
            end else if (paddr == AST_OFF_PRIO) begin
                next_s.prdata[7:0] = s.prio;
            end else if (paddr == AST_OFF_RCSC) begin
                next_s.prdata[7:0] = {s.rcsc[7:3], s.framing_error_flag,
                                      s.overrun_error_flag, s.received_ninth_bit};
            end else if (paddr == AST_OFF_TXBUF) begin
                next_s.prdata[7:0] = s.tx_data;
            end else if (paddr == AST_OFF_TXSC) begin
                next_s.prdata[7:0] = s.txsc;
                next_s.prdata[AST_B_RSV]  = 1'b0;
                next_s.prdata[AST_B_SHIFTER_EMPTY_STATUS] = ~s.tx_busy;
            end else if (paddr == AST_OFF_BAUD) begin
                next_s.prdata[7:0] = s.baud;
            end else if (paddr == AST_OFF_RXBUF) begin
                next_s.prdata[7:0] = s.rx_data;
            end else begin
                // No address reaches the shifter
                next_s.pslverr = 1'b1;
            end
        end

        // ----------------------------------------
        // APB access: writes and read side effects
        // ----------------------------------------
        if (rd_rx) begin
            next_s.receive_complete_flag = 1'b0; // Reading empties the buffer
        end
        if (acc && pwrite) begin
            if (paddr == AST_OFF_INTCTL) begin
                next_s.intctl = pwdata[7:0];
            end else if (paddr == AST_OFF_ENAB) begin
                next_s.enab = pwdata[7:0];
            end else if (paddr == AST_OFF_PRIO) begin
                next_s.prio = pwdata[7:0];
            end else if (paddr == AST_OFF_RCSC) begin
                next_s.rcsc = {pwdata[7:3], 3'b000};
            end else if (paddr == AST_OFF_TXBUF) begin
                // Write lands after any same-cycle load
                next_s.tx_data  = pwdata[7:0];
                next_s.buf_full = tx_on;
            end else if (paddr == AST_OFF_TXSC) begin
                next_s.txsc = pwdata[7:0];
            end else if (paddr == AST_OFF_BAUD) begin
                next_s.baud = pwdata[7:0];
            end
            // Flag register writes are ignored
        end

        // Word complete: set wins over any read above
        if (rx_on && s.rx_st == AST_RX_STOP && os_tick
            && s.rx_os == AST_OS_LAST) begin
            if (rx_full) begin
                next_s.overrun_error_flag = 1'b1;
            end else if (s.rcsc[AST_B_ADDRESS_DETECT_ENABLE] && s.rcsc[AST_B_RX9]
                         && !ninth) begin
                // Data word for another station: dropped
                next_s.receive_complete_flag = next_s.receive_complete_flag;
            end else begin
                next_s.rx_data = rx_word;
                next_s.received_ninth_bit = s.rcsc[AST_B_RX9] & ninth;
                next_s.framing_error_flag = ~rx_in;
                next_s.receive_complete_flag = 1'b1;
            end
        end

        // Clearing continuous enable clears error state
        if (!s.rcsc[AST_B_CONTINUOUS_RECEIVE_ENABLE]) begin
            next_s.overrun_error_flag = 1'b0;
            next_s.framing_error_flag = 1'b0;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s          <= '0;
            s.intctl   <= AST_RST_INTCTL;
            s.enab     <= AST_RST_ENAB;
            s.prio     <= AST_RST_PRIO;
            s.rcsc     <= AST_RST_RCSC;
            s.txsc     <= AST_RST_TXSC;
            s.baud     <= AST_RST_BAUD;
            s.tx_sh    <= 11'h7FF;
            s.rx_st    <= AST_RX_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata  = s.prdata;
    assign pslverr = s.pslverr;
    assign pready  = 1'b1; // Zero-wait slave
    // Line idles high between frames
    assign tx_out  = s.tx_busy ? s.tx_sh[0] : 1'b1;
    assign tx_out_enable = port_enable;
    assign tx_irq_request = s.tx_buffer_empty_flag & s.enab[AST_B_TX_BUFFER_EMPTY_FLAG];
    assign rx_irq_request = s.receive_complete_flag & s.enab[AST_B_RECEIVE_COMPLETE_FLAG]
                          & s.intctl[AST_B_GIE];
    assign rx_irq_high_priority = s.prio[AST_B_RECEIVE_COMPLETE_FLAG];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_tx_reload_idle;
        @(posedge pclk) disable iff (!presetn)
        tx_load |-> !s.tx_busy ##1 s.tx_busy;
    endproperty
    a_tx_reload_idle: assert property (p_tx_reload_idle)
        else $error("shifter reloaded while busy");

    property p_load_one_cycle;
        @(posedge pclk) disable iff (!presetn)
        tx_load && !(acc && pwrite && paddr == AST_OFF_TXBUF)
        |=> !s.buf_full ##1 s.tx_buffer_empty_flag;
    endproperty
    a_load_one_cycle: assert property (p_load_one_cycle)
        else $error("buffer not emptied by load");

    property p_flag_clears_on_write;
        @(posedge pclk) disable iff (!presetn)
        $fell(s.tx_buffer_empty_flag) |-> $past(s.buf_full) || !$past(tx_on);
    endproperty
    a_flag_clears_on_write: assert property (p_flag_clears_on_write)
        else $error("empty flag cleared without write");

    property p_tx_mask;
        @(posedge pclk) disable iff (!presetn)
        s.tx_buffer_empty_flag && !s.enab[AST_B_TX_BUFFER_EMPTY_FLAG] |-> !tx_irq_request;
    endproperty
    a_tx_mask: assert property (p_tx_mask)
        else $error("masked transmit request seen");

    property p_flag_lag;
        @(posedge pclk) disable iff (!presetn)
        acc && pwrite && paddr == AST_OFF_TXBUF && tx_on
        && s.tx_busy |-> ##1 $stable(s.tx_buffer_empty_flag) ##1 !s.tx_buffer_empty_flag;
    endproperty
    a_flag_lag: assert property (p_flag_lag)
        else $error("empty flag timing wrong after write");

    property p_transmit_enable_sets_flag;
        @(posedge pclk) disable iff (!presetn)
        tx_on && !s.buf_full |=> s.tx_buffer_empty_flag;
    endproperty
    a_transmit_enable_sets_flag: assert property (p_transmit_enable_sets_flag)
        else $error("empty flag not set");

    property p_start_bit;
        @(posedge pclk) disable iff (!presetn)
        tx_load |=> !tx_out;
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("frame does not open with start bit");

    property p_rx_irq_gate;
        @(posedge pclk) disable iff (!presetn)
        rx_irq_request |-> s.intctl[AST_B_GIE]
                           && s.enab[AST_B_RECEIVE_COMPLETE_FLAG] && s.receive_complete_flag;
    endproperty
    a_rx_irq_gate: assert property (p_rx_irq_gate)
        else $error("receive request without enables");

    property p_err_clear;
        @(posedge pclk) disable iff (!presetn)
        !s.rcsc[AST_B_CONTINUOUS_RECEIVE_ENABLE] |=> !s.overrun_error_flag && !s.framing_error_flag;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("errors survive receive disable");

    property p_overrun_blocks;
        @(posedge pclk) disable iff (!presetn)
        s.overrun_error_flag && s.rx_st == AST_RX_IDLE |=> s.rx_st == AST_RX_IDLE;
    endproperty
    a_overrun_blocks: assert property (p_overrun_blocks)
        else $error("reception after overrun");
endmodule // ast_uart
`default_nettype wire

// ===== ast_remote.sv
`timescale 1ns/1ps
`default_nettype none
// Remote station: drives the receive line, decodes the transmit line
module ast_remote (
    input  wire logic pclk,
    input  wire logic tx_line,
    output logic      rx_line
);
    int         bclk  = 32; // Clocks per bit, set by the bench
    int         nbits = 8;  // Data bits per frame
    logic [9:0] q[$];       // Decoded words, stop bit on top
    initial rx_line = 1'b1; // Idle high between frames
    // -------------------------------------------------
    // Sender: a bad stop is cut short so no false start
    // -------------------------------------------------
    task automatic send(input logic [8:0] w, input logic stop);
        for (int i = 0; i < nbits + 3; i++) begin
            rx_line <= (i == 0) ? 1'b0 : (i <= nbits) ? w[i-1]
                     : (i == nbits + 1) ? stop : 1'b1;
            repeat (bclk - ((i == nbits + 1 && !stop) ? bclk / 4 : 0))
                @(posedge pclk);
        end
    endtask
    // -------------------------------------------------
    // Monitor: centre sample of each bit, LSB first
    // -------------------------------------------------
    always begin : mon
        logic [9:0] w;
        @(negedge tx_line);
        w = '0;
        repeat (bclk / 2) @(posedge pclk);
        for (int i = 0; i < nbits; i++) begin
            repeat (bclk) @(posedge pclk);
            w[i] = tx_line;
        end
        repeat (bclk) @(posedge pclk);
        w[9] = tx_line;
        q.push_back(w);
    end
endmodule // ast_remote
`default_nettype wire

// ===== ast_uart_test.sv
`timescale 1ns/1ps
`default_nettype none
module ast_uart_test;
    import ast_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, rx_in;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, tx_out, tx_oe, tx_irq, rx_irq, rx_hi;
    logic [8:0]  b, c;
    int          miscompares = 0;
    int          n_compared  = 0;
    logic [7:0]  ofs [8] = '{AST_OFF_INTCTL, AST_OFF_FLAGS, AST_OFF_ENAB,
        AST_OFF_PRIO, AST_OFF_RCSC, AST_OFF_TXSC, AST_OFF_BAUD,
        AST_OFF_RXBUF};
    logic [7:0]  rst [8] = '{AST_RST_INTCTL, 8'h00, AST_RST_ENAB,
        AST_RST_PRIO, AST_RST_RCSC, AST_RST_TXSC, AST_RST_BAUD, 8'h00};
    ast_uart ast_uart_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out),
        .tx_out_enable(tx_oe), .tx_irq_request(tx_irq),
        .rx_irq_request(rx_irq), .rx_irq_high_priority(rx_hi));
    ast_remote ast_remote_inst (.pclk(pclk), .tx_line(tx_out),
        .rx_line(rx_in));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Clocks per bit: tick per (baud+1) clocks, four times slower if low
    function automatic int exp_bclk(input logic hs, input logic [7:0] d);
        return (hs ? 16 : 64) * (int'(d) + 1);
    endfunction
    // Word as the line shows it: stop on top, ninth bit only if sent
    function automatic logic [9:0] frame(input logic n, input logic [8:0] w);
        return {1'b1, n & w[8], w[7:0]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // APB master: waits for pready, never assumes a latency
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(r, {24'h0, e});
    endtask
    // Waits for k decoded words, then lets the stop bit end
    task automatic wait_tx(input int k);
        for (int t = 0; t < 20000 && ast_remote_inst.q.size() < k; t++)
            @(posedge pclk);
        repeat (ast_remote_inst.bclk) @(posedge pclk);
    endtask
    task automatic wrap_up();
        if (miscompares == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge pclk);
        miscompares++;
        wrap_up();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        void'($urandom(97208));
        ast_remote_inst.bclk = exp_bclk(1'b1, 8'h01);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ofs[i]) rd(ofs[i], rst[i]);
        apb(1'b0, 8'h24, 8'h00);
        chk(pslverr, 1);
        apb(1'b1, AST_OFF_BAUD, 8'h01);
        apb(1'b1, AST_OFF_RCSC, 8'h90);
        apb(1'b1, AST_OFF_TXSC, 8'h24);
        rd(AST_OFF_FLAGS, 8'h10);
        chk(tx_oe, 1);
        chk(tx_irq, 0);
        chk(rx_hi, 1);
        apb(1'b1, AST_OFF_ENAB, 8'h10);
        apb(1'b1, AST_OFF_PRIO, 8'h00);
        // Let the write edge settle before looking at the outputs
        @(negedge pclk);
        chk(tx_irq, 1);
        chk(rx_hi, 0);
        // Two words back to back, the second waits in the buffer
        b = 9'($urandom);
        c = 9'($urandom);
        apb(1'b1, AST_OFF_TXBUF, b[7:0]);
        apb(1'b1, AST_OFF_TXBUF, c[7:0]);
        rd(AST_OFF_FLAGS, 8'h00);
        rd(AST_OFF_TXSC, 8'h24);
        wait_tx(2);
        chk(ast_remote_inst.q[0], frame(0, b));
        chk(ast_remote_inst.q[1], frame(0, c));
        apb(1'b1, AST_OFF_FLAGS, 8'h00);
        rd(AST_OFF_FLAGS, 8'h10);
        rd(AST_OFF_TXSC, 8'h26);
        ast_remote_inst.q.delete();
        ast_remote_inst.nbits = 9;
        apb(1'b1, AST_OFF_TXSC, 8'h65);
        apb(1'b1, AST_OFF_TXBUF, b[7:0]);
        wait_tx(1);
        chk(ast_remote_inst.q[0], frame(1, 9'h100 | b));
        // Reception, interrupt gated by the global enable
        ast_remote_inst.nbits = 8;
        apb(1'b1, AST_OFF_INTCTL, 8'h80);
        apb(1'b1, AST_OFF_ENAB, 8'h20);
        ast_remote_inst.send(b, 1'b1);
        chk(rx_irq, 1);
        rd(AST_OFF_FLAGS, 8'h30);
        rd(AST_OFF_RCSC, 8'h90);
        rd(AST_OFF_RXBUF, b[7:0]);
        apb(1'b1, AST_OFF_INTCTL, 8'h00);
        ast_remote_inst.send(c, 1'b1);
        chk(rx_irq, 0);
        rd(AST_OFF_RXBUF, c[7:0]);
        // Framing error, then continuous enable cleared and off
        ast_remote_inst.send(b, 1'b0);
        rd(AST_OFF_RCSC, 8'h94);
        rd(AST_OFF_RXBUF, b[7:0]);
        apb(1'b1, AST_OFF_RCSC, 8'h80);
        rd(AST_OFF_RCSC, 8'h80);
        ast_remote_inst.send(c, 1'b1);
        rd(AST_OFF_FLAGS, 8'h10);
        // Overrun: second word lost, third blocked
        apb(1'b1, AST_OFF_RCSC, 8'h90);
        ast_remote_inst.send(b, 1'b1);
        ast_remote_inst.send(c, 1'b1);
        rd(AST_OFF_RCSC, 8'h92);
        rd(AST_OFF_RXBUF, b[7:0]);
        ast_remote_inst.send(c, 1'b1);
        rd(AST_OFF_FLAGS, 8'h10);
        apb(1'b1, AST_OFF_RCSC, 8'h80);
        // Nine bits with address detect, then detect off
        apb(1'b1, AST_OFF_RCSC, 8'hD8);
        ast_remote_inst.nbits = 9;
        ast_remote_inst.send({1'b0, b[7:0]}, 1'b1);
        rd(AST_OFF_FLAGS, 8'h10);
        ast_remote_inst.send({1'b1, c[7:0]}, 1'b1);
        rd(AST_OFF_RCSC, 8'hD9);
        rd(AST_OFF_RXBUF, c[7:0]);
        apb(1'b1, AST_OFF_RCSC, 8'hD0);
        ast_remote_inst.send({1'b0, b[7:0]}, 1'b1);
        rd(AST_OFF_FLAGS, 8'h30);
        rd(AST_OFF_RXBUF, b[7:0]);
        // Low-speed generator, four times longer bits
        apb(1'b1, AST_OFF_TXSC, 8'h20);
        ast_remote_inst.bclk = exp_bclk(1'b0, 8'h01);
        ast_remote_inst.nbits = 8;
        ast_remote_inst.q.delete();
        apb(1'b1, AST_OFF_TXBUF, c[7:0]);
        wait_tx(1);
        chk(ast_remote_inst.q[0], frame(0, c));
        wrap_up();
    end
endmodule // ast_uart_test
`default_nettype wire
